// ===== verilog/ucp_pkg.sv
// Purpose: constants for the serial primary control block
// Assumes: AXI4-Lite register access, 40 MHz aclk
// Notes: register byte address is four times the register index
package ucp_pkg;
    localparam logic [11:0] CTL_IDX = 12'hf42;
    localparam logic [11:0] TXD_IDX = 12'hf40;
    localparam logic [11:0] STAT_IDX = 12'hf41;
    localparam logic [11:0] RXD_IDX = 12'hf43;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam int TX_ON_BIT = 7;
    localparam int RX_ON_BIT = 6;
    localparam int CTS_GATE_BIT = 5;
    localparam int PARITY_BIT = 4;
    localparam int PAR_ODD_BIT = 3;
    localparam int BREAK_BIT = 2;
    localparam int STOP_TWO_BIT = 1;
    localparam int LOOP_BIT = 0;
    localparam int CLK_HZ = 40000000;
    localparam int BAUD_HZ = 115200;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [6:0] {
        UCP_TX_IDLE = 7'h01, UCP_TX_START = 7'h02, UCP_TX_DATA = 7'h04,
        UCP_TX_EXTRA = 7'h08, UCP_TX_STOP = 7'h10, UCP_TX_BRK = 7'h20,
        UCP_TX_BSTOP = 7'h40
    } ucp_tx_t;
    typedef enum logic [3:0] {
        UCP_RX_IDLE = 4'h1, UCP_RX_START = 4'h2, UCP_RX_BITS = 4'h4, UCP_RX_STOP = 4'h8
    } ucp_rx_t;
endpackage : ucp_pkg

// ===== verilog/ucp_uart.sv
// Purpose: serial unit under the primary control register, with transmit FIFO
// Assumes: inputs synchronous to aclk, fixed bit rate from the package
// Notes: status and data registers sit beside the control register
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module ucp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data = mem[rd_ptr_reg[AW-1:0]];
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
        end
    end
endmodule : ucp_fifo

////////////////////////////////////////////////////////////////////////////////

module ucp_uart (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cts_n,
    input wire logic rxd,
    input wire logic lin_mode_on,
    input wire logic nine_bit_mode_on,
    input wire logic nine_bit_value,
    input wire logic [3:0] tx_break_duration,
    output logic txd,
    output logic tx_shift_idle
);
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_hold_reg, w_hold_reg;
    logic [13:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic w_strb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [7:0] ctl_reg, rx_byte_reg, tx_byte_reg;
    logic rx_full_reg, rx_par_err_reg, rx_frame_err_reg, rx_ninth_reg;
    logic txd_int_reg, txd_reg, idle_reg, break_clr;
    logic tx_extra_reg, tx_ninth_reg;
    logic [15:0] tx_tmr_reg, rx_tmr_reg;
    logic [3:0] tx_idx_reg, rx_idx_reg;
    logic [8:0] rx_sh_reg;
    ucp_pkg::ucp_tx_t tx_state_reg;
    ucp_pkg::ucp_rx_t rx_state_reg;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [7:0] fifo_out_data;

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign txd = txd_reg;
    assign tx_shift_idle = idle_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    wire tx_on = ctl_reg[ucp_pkg::TX_ON_BIT];
    wire rx_on = ctl_reg[ucp_pkg::RX_ON_BIT];
    wire cts_gate_on = ctl_reg[ucp_pkg::CTS_GATE_BIT];
    wire parity_on = ctl_reg[ucp_pkg::PARITY_BIT];
    wire parity_odd = ctl_reg[ucp_pkg::PAR_ODD_BIT];
    wire break_send = ctl_reg[ucp_pkg::BREAK_BIT];
    wire stop_two = ctl_reg[ucp_pkg::STOP_TWO_BIT];
    wire loopback_on = ctl_reg[ucp_pkg::LOOP_BIT];
    wire parity_eff = parity_on && !nine_bit_mode_on;
    wire extra_on = parity_eff || nine_bit_mode_on;
    wire tx_go = tx_on && (!cts_gate_on || !cts_n);
    wire rx_in = loopback_on ? txd_int_reg : rxd;
    wire [11:0] w_idx = aw_addr_reg[13:2];
    wire w_ctl = w_idx == ucp_pkg::CTL_IDX;
    wire w_txd = w_idx == ucp_pkg::TXD_IDX;
    wire w_ok = w_ctl || w_txd;
    // Writes to the data register wait while the FIFO is full
    wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg && (!w_txd || fifo_in_ready);
    wire wr_ctl = do_write && w_ctl && w_strb_reg;
    wire push_txd = do_write && w_txd && w_strb_reg;
    wire [11:0] r_idx = s_axi_araddr[13:2];
    wire r_hit = s_axi_araddr[31:14] == 18'h00000;
    wire rd_go = s_axi_arvalid && arready_reg;
    wire rd_rxd = rd_go && r_hit && r_idx == ucp_pkg::RXD_IDX;
    wire [7:0] stat_val = {3'h0, rx_ninth_reg, rx_frame_err_reg, rx_par_err_reg,
                           rx_full_reg, idle_reg};
    wire [7:0] rd_val = (r_idx == ucp_pkg::CTL_IDX) ? ctl_reg :
                        (r_idx == ucp_pkg::STAT_IDX) ? stat_val :
                        (r_idx == ucp_pkg::RXD_IDX) ? rx_byte_reg : 8'h00;
    wire rd_ok = r_hit && (r_idx == ucp_pkg::CTL_IDX || r_idx == ucp_pkg::STAT_IDX ||
                 r_idx == ucp_pkg::RXD_IDX || r_idx == ucp_pkg::TXD_IDX);

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= ucp_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                aw_hold_reg <= 1'b1;
                awready_reg <= 1'b0;
                aw_addr_reg <= s_axi_awaddr[13:0];
                if (s_axi_awaddr[31:14] != 18'h00000) begin
                    aw_addr_reg <= 14'h0000;
                end
            end
            if (s_axi_wvalid && wready_reg) begin
                w_hold_reg <= 1'b1;
                wready_reg <= 1'b0;
                w_data_reg <= s_axi_wdata[7:0];
                w_strb_reg <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= w_ok ? ucp_pkg::RESP_OKAY : ucp_pkg::RESP_SLVERR;
            end
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= ucp_pkg::RESP_OKAY;
        end else if (rd_go) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h000000, rd_val};
            rresp_reg <= rd_ok ? ucp_pkg::RESP_OKAY : ucp_pkg::RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // Software write wins over the hardware clear of break_send
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_reg <= ucp_pkg::CTL_RESET;
        end else if (wr_ctl) begin
            ctl_reg <= w_data_reg;
        end else if (break_clr) begin
            ctl_reg[ucp_pkg::BREAK_BIT] <= 1'b0;
        end
    end

    ucp_fifo #(.WIDTH(ucp_pkg::FIFO_WIDTH), .DEPTH(ucp_pkg::FIFO_DEPTH)) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_data(w_data_reg),
        .in_valid(push_txd),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter
    wire tx_tick = tx_tmr_reg == 16'h0000;
    wire tx_load = tx_state_reg == ucp_pkg::UCP_TX_IDLE && !break_send && fifo_out_valid && tx_go;
    assign fifo_pop = tx_load;
    assign break_clr = tx_state_reg == ucp_pkg::UCP_TX_BRK && lin_mode_on && tx_tick &&
                       tx_idx_reg >= tx_break_duration;
    wire [3:0] stop_last = stop_two ? 4'h1 : 4'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state_reg <= ucp_pkg::UCP_TX_IDLE;
            tx_tmr_reg <= 16'h0000;
            tx_idx_reg <= 4'h0;
            tx_byte_reg <= 8'h00;
            tx_extra_reg <= 1'b0;
            tx_ninth_reg <= 1'b0;
            txd_int_reg <= 1'b1;
        end else begin
            tx_tmr_reg <= tx_tick ? ucp_pkg::BIT_LAST : tx_tmr_reg - 16'h0001;
            case (tx_state_reg)
                ucp_pkg::UCP_TX_IDLE: begin
                    txd_int_reg <= 1'b1;
                    if (tx_load) begin
                        tx_byte_reg <= fifo_out_data;
                        tx_extra_reg <= extra_on;
                        // parity or ninth bit fixed at load
                        tx_ninth_reg <= nine_bit_mode_on ? nine_bit_value :
                                        (^fifo_out_data) ^ parity_odd;
                        tx_tmr_reg <= ucp_pkg::BIT_LAST;
                        tx_state_reg <= ucp_pkg::UCP_TX_START;
                        txd_int_reg <= 1'b0;
                    end
                end
                ucp_pkg::UCP_TX_START: if (tx_tick) begin
                    tx_state_reg <= ucp_pkg::UCP_TX_DATA;
                    tx_idx_reg <= 4'h0;
                    txd_int_reg <= tx_byte_reg[0];
                end
                ucp_pkg::UCP_TX_DATA: if (tx_tick) begin
                    tx_idx_reg <= tx_idx_reg + 4'h1;
                    txd_int_reg <= tx_byte_reg[3'(tx_idx_reg + 4'h1)];
                    if (tx_idx_reg == 4'h7) begin
                        tx_idx_reg <= 4'h0;
                        tx_state_reg <= tx_extra_reg ? ucp_pkg::UCP_TX_EXTRA
                                                     : ucp_pkg::UCP_TX_STOP;
                        txd_int_reg <= tx_extra_reg ? tx_ninth_reg : 1'b1;
                    end
                end
                ucp_pkg::UCP_TX_EXTRA: if (tx_tick) begin
                    tx_state_reg <= ucp_pkg::UCP_TX_STOP;
                    txd_int_reg <= 1'b1;
                end
                ucp_pkg::UCP_TX_STOP, ucp_pkg::UCP_TX_BSTOP: if (tx_tick) begin
                    tx_idx_reg <= tx_idx_reg + 4'h1;
                    if (tx_idx_reg >= stop_last) begin
                        tx_state_reg <= ucp_pkg::UCP_TX_IDLE;
                    end
                end
                ucp_pkg::UCP_TX_BRK: begin
                    txd_int_reg <= 1'b0;
                    if (tx_tick) begin
                        tx_idx_reg <= tx_idx_reg + 4'h1;
                    end
                    if (break_clr) begin
                        tx_state_reg <= ucp_pkg::UCP_TX_BSTOP;
                        tx_idx_reg <= 4'h0;
                        txd_int_reg <= 1'b1;
                    end else if (!lin_mode_on && !break_send) begin
                        tx_state_reg <= ucp_pkg::UCP_TX_IDLE;
                        txd_int_reg <= 1'b1;
                    end
                end
                default: tx_state_reg <= ucp_pkg::UCP_TX_IDLE;
            endcase
            // A new break cuts off whatever character is on the wire
            if (break_send && !break_clr && tx_state_reg != ucp_pkg::UCP_TX_BRK &&
                tx_state_reg != ucp_pkg::UCP_TX_BSTOP) begin
                tx_state_reg <= ucp_pkg::UCP_TX_BRK;
                tx_tmr_reg <= ucp_pkg::BIT_LAST;
                tx_idx_reg <= 4'h0;
                txd_int_reg <= 1'b0;
            end
        end
    end

    // Line is parked high during loopback so the peer sees no traffic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txd_reg <= 1'b1;
            idle_reg <= 1'b1;
        end else begin
            txd_reg <= loopback_on ? 1'b1 : txd_int_reg;
            idle_reg <= tx_state_reg == ucp_pkg::UCP_TX_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver: samples mid-bit, no noise filter
    wire rx_tick = rx_tmr_reg == 16'h0000;
    wire [3:0] rx_last = extra_on ? 4'h8 : 4'h7;
    wire rx_done = rx_state_reg == ucp_pkg::UCP_RX_STOP && rx_tick;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_state_reg <= ucp_pkg::UCP_RX_IDLE;
            rx_tmr_reg <= 16'h0000;
            rx_idx_reg <= 4'h0;
            rx_sh_reg <= 9'h000;
        end else begin
            rx_tmr_reg <= rx_tick ? ucp_pkg::BIT_LAST : rx_tmr_reg - 16'h0001;
            case (rx_state_reg)
                ucp_pkg::UCP_RX_IDLE: if (rx_on && !rx_in) begin
                    rx_state_reg <= ucp_pkg::UCP_RX_START;
                    rx_tmr_reg <= ucp_pkg::HALF_LAST;
                end
                ucp_pkg::UCP_RX_START: if (rx_tick) begin
                    rx_idx_reg <= 4'h0;
                    rx_state_reg <= rx_in ? ucp_pkg::UCP_RX_IDLE : ucp_pkg::UCP_RX_BITS;
                end
                ucp_pkg::UCP_RX_BITS: if (rx_tick) begin
                    rx_sh_reg[rx_idx_reg] <= rx_in;
                    rx_idx_reg <= rx_idx_reg + 4'h1;
                    if (rx_idx_reg == rx_last) begin
                        rx_state_reg <= ucp_pkg::UCP_RX_STOP;
                    end
                end
                ucp_pkg::UCP_RX_STOP: if (rx_tick) begin
                    rx_state_reg <= ucp_pkg::UCP_RX_IDLE;
                end
                default: rx_state_reg <= ucp_pkg::UCP_RX_IDLE;
            endcase
            if (!rx_on) begin
                rx_state_reg <= ucp_pkg::UCP_RX_IDLE;
            end
        end
    end

    // Flags set on a completed character; a same-cycle data read loses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_byte_reg <= 8'h00;
            rx_full_reg <= 1'b0;
            rx_par_err_reg <= 1'b0;
            rx_frame_err_reg <= 1'b0;
            rx_ninth_reg <= 1'b0;
        end else if (rx_done) begin
            rx_byte_reg <= rx_sh_reg[7:0];
            rx_full_reg <= 1'b1;
            rx_frame_err_reg <= !rx_in;
            rx_ninth_reg <= nine_bit_mode_on && rx_sh_reg[8];
            rx_par_err_reg <= parity_eff &&
                              ((^rx_sh_reg[7:0]) ^ parity_odd) != rx_sh_reg[8];
        end else if (rd_rxd) begin
            rx_full_reg <= 1'b0;
            rx_par_err_reg <= 1'b0;
            rx_frame_err_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence brk_end_s;
        break_clr ##1 (tx_state_reg == ucp_pkg::UCP_TX_BSTOP && txd_int_reg);
    endsequence

    tx_off_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tx_state_reg == ucp_pkg::UCP_TX_IDLE && !tx_on) |=>
        tx_state_reg != ucp_pkg::UCP_TX_START) else $error("start while tx off");
    cts_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tx_state_reg == ucp_pkg::UCP_TX_IDLE && cts_gate_on && cts_n) |=>
        tx_state_reg != ucp_pkg::UCP_TX_START) else $error("start with cts high");
    rx_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !rx_on |=> rx_state_reg == ucp_pkg::UCP_RX_IDLE) else $error("rx ran while off");
    nine_no_par_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tx_state_reg == ucp_pkg::UCP_TX_DATA && tx_idx_reg == 4'h7 && tx_tick &&
         !extra_on && !break_send) |=> tx_state_reg == ucp_pkg::UCP_TX_STOP)
        else $error("extra bit sent");
    par_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tx_state_reg == ucp_pkg::UCP_TX_EXTRA && !nine_bit_mode_on) |->
        txd_int_reg == ((^tx_byte_reg) ^ $past(parity_odd, 1))) else $error("bad parity");
    break_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (break_send && !break_clr) |=> !txd_int_reg) else $error("break not low");
    break_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!lin_mode_on && break_send && !wr_ctl) |=> break_send)
        else $error("break cleared by hardware");
    lin_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        break_clr |-> brk_end_s) else $error("no stop after break");
    loop_park_a: assert property (@(posedge aclk) disable iff (!aresetn)
        loopback_on |=> txd_reg) else $error("line driven in loopback");
    idle_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(tx_state_reg == ucp_pkg::UCP_TX_IDLE) |=> idle_reg) else $error("idle late");
endmodule : ucp_uart

`default_nettype wire

// ===== bench/ucp_peer.sv
// Purpose: remote serial node on the transmit and receive lines
// Assumes: idle-high lines, bit time from the package
// Notes: captures eleven mid-bit samples after each falling edge outside a capture
`timescale 1ns/1ps
`default_nettype none
module ucp_peer (
    input wire logic aclk,
    input wire logic line_in,
    output logic line_out
);
    logic [10:0] cap;
    initial begin
        line_out = 1'b1;
        cap = 11'h000;
    end
    // A break also starts a capture; tests wait it out before the next frame
    always begin
        @(negedge line_in);
        repeat (ucp_pkg::BIT_CYCLES / 2) @(posedge aclk);
        for (int i = 0; i < 11; i++) begin
            repeat (ucp_pkg::BIT_CYCLES) @(posedge aclk);
            cap[i] = line_in;
        end
    end
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge aclk);
            line_out <= f[i];
            repeat (ucp_pkg::BIT_CYCLES - 1) @(posedge aclk);
        end
    endtask : send_byte
endmodule : ucp_peer
`default_nettype wire

// ===== bench/uart_primary_control_test.sv
// Purpose: register-level checks of the primary control block
// Assumes: byte address is four times the register index
// Notes: frames are judged by the peer's mid-bit samples
`timescale 1ns/1ps
`default_nettype none
module uart_primary_control_test;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb, tx_break_duration;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic cts_n, rxd, lin_mode_on, nine_bit_mode_on, nine_bit_value, txd, tx_shift_idle;
    logic [31:0] rd;
    int fail_count = 0;
    int n_checks = 0;
    localparam logic [31:0] A_CTL = 32'h00003d08;
    localparam logic [31:0] A_TXD = 32'h00003d00;
    localparam logic [31:0] A_ST = 32'h00003d04;
    localparam logic [31:0] A_RXD = 32'h00003d0c;
    localparam int BT = ucp_pkg::BIT_CYCLES;
    ucp_uart DUT (.*);
    ucp_peer peer (.aclk(aclk), .line_in(txd), .line_out(rxd));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wait_bits(input int n);
        repeat (n * BT) @(posedge aclk);
    endtask : wait_bits
    // Registered readies mean values seen just after the edge are those it sampled
    task automatic axi_wr(input logic [31:0] a, input logic [7:0] d);
        int t;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (t = 0; t < 1000; t++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (t == 1000) fail_count++;
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] a);
        int t;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (t = 0; t < 1000; t++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (t == 1000) fail_count++;
    endtask : axi_rd
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (80000) @(posedge aclk);
        fail_count++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = {32'h0, 32'h0, 32'h0};
        s_axi_wstrb = 4'h1;
        {cts_n, lin_mode_on, nine_bit_mode_on, nine_bit_value} = 4'h8;
        tx_break_duration = 4'h1;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(A_CTL);
        chk("ctl reset", 32'h00000000, rd);
        axi_rd(32'h00003ff0);
        chk("unmapped resp", 32'h2, 32'(rsp));
        axi_wr(32'h00003ff0, 8'h00);
        chk("unmapped wr resp", 32'h2, 32'(rsp));
        chk("idle flag", 32'h1, 32'(tx_shift_idle));
        $display("test reset done");
        axi_wr(A_TXD, 8'h55);
        wait_bits(2);
        chk("tx off line", 32'h1, 32'(txd));
        axi_wr(A_CTL, 8'ha0);
        chk("ctl wr resp", 32'h0, 32'(rsp));
        wait_bits(2);
        chk("cts high line", 32'h1, 32'(txd));
        cts_n <= 1'b0;
        wait_bits(14);
        chk("frame one stop", 32'h155, 32'(peer.cap[8:0]));
        $display("test enable done");
        for (int k = 0; k < 2; k++) begin
            axi_wr(A_CTL, k ? 8'h9a : 8'h92);
            axi_wr(A_TXD, 8'ha3);
            // Half a bit into the twelfth bit time only a second stop bit keeps it busy
            wait_bits(11);
            repeat (BT / 2) @(posedge aclk);
            chk("two stop busy", 32'h0, 32'(tx_shift_idle));
            wait_bits(3);
            chk("parity frame", k ? 32'h7a3 : 32'h6a3, 32'(peer.cap));
            chk("idle after frame", 32'h1, 32'(tx_shift_idle));
        end
        nine_bit_mode_on <= 1'b1;
        axi_wr(A_CTL, 8'h98);
        axi_wr(A_TXD, 8'ha3);
        wait_bits(14);
        chk("ninth bit", 32'h2a3, 32'(peer.cap[9:0]));
        nine_bit_mode_on <= 1'b0;
        $display("test format done");
        // All-ones data keeps the line high, so an unaborted character shows up
        axi_wr(A_TXD, 8'hff);
        wait_bits(2);
        axi_wr(A_CTL, 8'h84);
        wait_bits(4);
        chk("break line", 32'h0, 32'(txd));
        axi_rd(A_CTL);
        chk("break held", 32'h84, rd);
        axi_wr(A_CTL, 8'h80);
        wait_bits(12);
        chk("after break", 32'h1, 32'(txd));
        lin_mode_on <= 1'b1;
        axi_wr(A_CTL, 8'h84);
        wait_bits(1);
        chk("lin break line", 32'h0, 32'(txd));
        wait_bits(4);
        axi_rd(A_CTL);
        chk("lin break cleared", 32'h80, rd);
        chk("lin stop level", 32'h1, 32'(txd));
        lin_mode_on <= 1'b0;
        wait_bits(8);
        $display("test break done");
        axi_wr(A_CTL, 8'hc1);
        axi_wr(A_TXD, 8'h3c);
        wait_bits(1);
        chk("loop line", 32'h1, 32'(txd));
        wait_bits(13);
        axi_rd(A_RXD);
        chk("loop data", 32'h3c, rd);
        axi_wr(A_CTL, 8'h80);
        peer.send_byte(8'h5a);
        axi_rd(A_ST);
        chk("rx off full", 32'h0, 32'(rd[1]));
        axi_wr(A_CTL, 8'h40);
        peer.send_byte(8'h5a);
        axi_rd(A_RXD);
        chk("rx data", 32'h5a, rd);
        $display("test receive done");
        report_and_stop();
    end
endmodule : uart_primary_control_test
`default_nettype wire
